// ---- src/hpr_params.svh ----
// Purpose: Offsets, field positions, reset values and counts for the homing sequencer
// Assumes: 32-bit AHB-Lite register word, byte addresses
// Notes:   Included by bare name
`ifndef HPR_PARAMS_SVH
`define HPR_PARAMS_SVH

// ==========================================================================
// Register offsets (byte addresses, low address byte)
`define HPR_OFF_METHOD    8'h00
`define HPR_OFF_DIR       8'h04
`define HPR_OFF_POL       8'h08
`define HPR_OFF_HSPEED    8'h0C
`define HPR_OFF_CREEP     8'h10
`define HPR_OFF_ACC       8'h14
`define HPR_OFF_DEC       8'h18
`define HPR_OFF_SHIFT     8'h1C
`define HPR_OFF_HADDR     8'h20
`define HPR_OFF_POSTDOG   8'h24
`define HPR_OFF_STATUS    8'h28
`define HPR_OFF_POSITION  8'h2C

// ==========================================================================
// Reset values
`define HPR_RST_METHOD    3'h0
`define HPR_RST_DIR       1'b1
`define HPR_RST_POL       1'b0
`define HPR_RST_SPEED     16'h0000
`define HPR_RST_TC        16'h0000
`define HPR_RST_DIST      32'h0000_0000

// ==========================================================================
// Mode select code for homing: bit2 off, bit1 off, bit0 on
`define HPR_MODE_HOMING   3'h1

// Steps per motor revolution for the internal index pulse
`define HPR_STEPS_PER_REV 16'h1000

// Status field positions
`define HPR_ST_STATE_LSB  0
`define HPR_ST_DOG        8
`define HPR_ST_HOMED      9
`define HPR_ST_BUSY       10

`endif

// ---- src/hpr_pkg.sv ----
// Purpose: Types for the homing sequencer
// Assumes: Constants live in hpr_params.svh
// Notes:   One-hot sequence states
package hpr_pkg;

   typedef enum logic [6:0] {
      HPR_IDLE   = 7'h01,
      HPR_SEEK   = 7'h02,
      HPR_REAR   = 7'h04,
      HPR_TRAVEL = 7'h08,
      HPR_ZWAIT  = 7'h10,
      HPR_SHIFT  = 7'h20,
      HPR_STOP   = 7'h40
   } hpr_state_t;

   typedef enum logic [2:0] {
      HPR_M_DOG       = 3'h0,
      HPR_M_COUNT     = 3'h1,
      HPR_M_DATASET   = 3'h2,
      HPR_M_IGNORE    = 3'h3,
      HPR_M_DOG_REAR  = 3'h4,
      HPR_M_CNT_FRONT = 3'h5,
      HPR_M_CRADLE    = 3'h6
   } hpr_method_t;

endpackage

// ---- src/hpr_ramp.sv ----
// Purpose: Speed ramp and step pulse generator
// Assumes: Same clock as the sequencer
// Notes:   Speed moves one unit per time-constant period
`timescale 1ns/1ps

module hpr_ramp (
   input  wire logic        clk,
   input  wire logic        rst_n,
   input  wire logic [15:0] target,
   input  wire logic [15:0] acc_tc,
   input  wire logic [15:0] dec_tc,
   output logic      [15:0] speed,
   output logic             step
);

   logic [15:0] tick_cnt_reg;
   logic [23:0] phase_reg;
   logic [24:0] phase_sum;
   logic [15:0] tc;

   assign tc        = (speed < target) ? acc_tc : dec_tc;
   assign phase_sum = {1'b0, phase_reg} + {9'h000, speed};
   assign step      = phase_sum[24];

   // ==========================================================================
   // Ramp toward target
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         tick_cnt_reg <= 16'h0000;
         speed        <= 16'h0000;
      end else if (speed == target) begin
         tick_cnt_reg <= 16'h0000;
      end else if (tick_cnt_reg >= tc) begin
         tick_cnt_reg <= 16'h0000;
         if (speed < target) begin
            speed <= speed + 16'h0001;
         end else begin
            speed <= speed - 16'h0001;
         end
      end else begin
         tick_cnt_reg <= tick_cnt_reg + 16'h0001;
      end
   end

   // ==========================================================================
   // Phase accumulator, carry is one step
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         phase_reg <= 24'h000000;
      end else begin
         phase_reg <= phase_sum[23:0];
      end
   end

endmodule

// ---- src/hpr_top.sv ----
// Purpose: Home position return sequencer with AHB-Lite register slave
// Assumes: One clock hclk at 40 MHz, asynchronous active-low hresetn
// Notes:   Step/direction command out, index derived from step count
//
// What this block does
// - Dog type: decel at front, index after rear
// - Count type: front, post-dog distance, next index
// - Data-set: current position becomes home, no dog
// - Ignore type: servo-on position is home
// - Rear reference: post-dog plus shift after rear
// - Front reference: post-dog plus shift after front
// - Cradle: first index after dog front
// - Index made internally per revolution, not output
// - Method, direction, polarity from their registers
// - Homing speed until dog, then creep speed
// - Homing acceleration and deceleration time constants
// - Shift, home address, post-dog distance registers
// - Start runs homing; start-direction input ignored
// - Polarity 1 closed active, 0 open active
// - On completion load home address as position
`timescale 1ns/1ps
`include "hpr_params.svh"

module hpr_top (
   input  wire logic        hclk,
   input  wire logic        hresetn,
   input  wire logic        hsel,
   input  wire logic [31:0] haddr,
   input  wire logic [1:0]  htrans,
   input  wire logic        hwrite,
   input  wire logic [2:0]  hsize,
   input  wire logic [31:0] hwdata,
   input  wire logic        hready,
   output logic      [31:0] hrdata,
   output logic             hreadyout,
   output logic             hresp,
   input  wire logic        mode_select_bit0,
   input  wire logic        mode_select_bit1,
   input  wire logic        mode_select_bit2,
   input  wire logic        motion_start_input,
   input  wire logic        start_direction_input,
   input  wire logic        dog_switch_input,
   input  wire logic        servo_on_input,
   output logic             step_pulse,
   output logic             step_dir,
   output logic             homing_busy,
   output logic             home_complete
);

   // ==========================================================================
   // Declarations
   hpr_pkg::hpr_state_t  state_reg;
   hpr_pkg::hpr_method_t method_reg;
   logic        dir_reg;
   logic        pol_reg;
   logic [15:0] hspeed_reg;
   logic [15:0] creep_reg;
   logic [15:0] acc_reg;
   logic [15:0] dec_reg;
   logic [31:0] shift_reg;
   logic [31:0] haddr_home_reg;
   logic [31:0] postdog_reg;
   logic [31:0] position_reg;
   logic [31:0] servo_on_pos_reg;
   logic [31:0] remain_reg;
   logic [15:0] rev_cnt_reg;
   logic        homed_reg;
   logic [5:0]  sync1_reg;
   logic [5:0]  sync2_reg;
   logic        start_prev_reg;
   logic        dog_prev_reg;
   logic        servo_prev_reg;
   logic        wr_pend_reg;
   logic [7:0]  wr_addr_reg;
   logic [15:0] target_speed;
   logic [15:0] cur_speed;
   logic        step;
   logic        dog_act;
   logic        dog_front;
   logic        dog_rear;
   logic        start_edge;
   logic        servo_edge;
   logic        homing_mode;
   logic        index_pulse;
   logic        complete;
   logic        addr_phase;
   logic [31:0] rd_mux;

   // Dog polarity: 1 closed contact is active, 0 open contact is active
   function automatic logic dog_level(input logic raw, input logic pol);
      dog_level = (raw == pol);
   endfunction

   // ==========================================================================
   // Pin synchronisers
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         sync1_reg <= 6'h00;
         sync2_reg <= 6'h00;
      end else begin
         sync1_reg <= {servo_on_input, dog_switch_input, motion_start_input,
                       mode_select_bit2, mode_select_bit1, mode_select_bit0};
         sync2_reg <= sync1_reg;
      end
   end

   assign homing_mode = sync2_reg[0] & ~sync2_reg[1] & ~sync2_reg[2];
   assign dog_act     = dog_level(sync2_reg[4], pol_reg);
   assign start_edge  = sync2_reg[3] & ~start_prev_reg;
   assign servo_edge  = sync2_reg[5] & ~servo_prev_reg;
   assign dog_front   = dog_act & ~dog_prev_reg;
   assign dog_rear    = ~dog_act & dog_prev_reg;

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         start_prev_reg <= 1'b0;
         dog_prev_reg   <= 1'b0;
         servo_prev_reg <= 1'b0;
      end else begin
         start_prev_reg <= sync2_reg[3];
         dog_prev_reg   <= dog_act;
         servo_prev_reg <= sync2_reg[5];
      end
   end

   // ==========================================================================
   // Speed selection and ramp
   always_comb begin
      case (state_reg)
         hpr_pkg::HPR_SEEK:   target_speed = hspeed_reg;
         hpr_pkg::HPR_REAR,
         hpr_pkg::HPR_TRAVEL,
         hpr_pkg::HPR_ZWAIT,
         hpr_pkg::HPR_SHIFT:  target_speed = creep_reg;
         default:             target_speed = 16'h0000;
      endcase
   end

   hpr_ramp u_ramp (
      .clk    (hclk),
      .rst_n  (hresetn),
      .target (target_speed),
      .acc_tc (acc_reg),
      .dec_tc (dec_reg),
      .speed  (cur_speed),
      .step   (step)
   );

   // ==========================================================================
   // Internal index, one per revolution, kept inside
   assign index_pulse = step && (rev_cnt_reg == `HPR_STEPS_PER_REV - 16'h0001);

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         rev_cnt_reg <= 16'h0000;
      end else if (index_pulse) begin
         rev_cnt_reg <= 16'h0000;
      end else if (step) begin
         rev_cnt_reg <= rev_cnt_reg + 16'h0001;
      end
   end

   // ==========================================================================
   // Homing sequence
   assign complete = (state_reg == hpr_pkg::HPR_STOP) && (cur_speed == 16'h0000);

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         state_reg  <= hpr_pkg::HPR_IDLE;
         remain_reg <= 32'h0000_0000;
      end else begin
         case (state_reg)
            hpr_pkg::HPR_IDLE: begin
               if (start_edge && homing_mode) begin
                  case (method_reg)
                     hpr_pkg::HPR_M_DATASET: state_reg <= hpr_pkg::HPR_STOP;
                     hpr_pkg::HPR_M_IGNORE:  state_reg <= hpr_pkg::HPR_IDLE;
                     default:                state_reg <= hpr_pkg::HPR_SEEK;
                  endcase
               end
            end
            hpr_pkg::HPR_SEEK: begin
               if (dog_front) begin
                  case (method_reg)
                     hpr_pkg::HPR_M_DOG,
                     hpr_pkg::HPR_M_DOG_REAR: state_reg <= hpr_pkg::HPR_REAR;
                     hpr_pkg::HPR_M_COUNT: begin
                        state_reg  <= hpr_pkg::HPR_TRAVEL;
                        remain_reg <= postdog_reg;
                     end
                     hpr_pkg::HPR_M_CNT_FRONT: begin
                        state_reg  <= hpr_pkg::HPR_TRAVEL;
                        remain_reg <= postdog_reg + shift_reg;
                     end
                     default: state_reg <= hpr_pkg::HPR_ZWAIT;
                  endcase
               end
            end
            hpr_pkg::HPR_REAR: begin
               if (dog_rear) begin
                  if (method_reg == hpr_pkg::HPR_M_DOG_REAR) begin
                     state_reg  <= hpr_pkg::HPR_TRAVEL;
                     remain_reg <= postdog_reg + shift_reg;
                  end else begin
                     state_reg <= hpr_pkg::HPR_ZWAIT;
                  end
               end
            end
            hpr_pkg::HPR_TRAVEL: begin
               if (remain_reg == 32'h0000_0000) begin
                  if (method_reg == hpr_pkg::HPR_M_COUNT) begin
                     state_reg <= hpr_pkg::HPR_ZWAIT;
                  end else begin
                     state_reg <= hpr_pkg::HPR_STOP;
                  end
               end else if (step) begin
                  remain_reg <= remain_reg - 32'h0000_0001;
               end
            end
            hpr_pkg::HPR_ZWAIT: begin
               if (index_pulse) begin
                  if (shift_reg == 32'h0000_0000 || method_reg == hpr_pkg::HPR_M_CRADLE) begin
                     state_reg <= hpr_pkg::HPR_STOP;
                  end else begin
                     state_reg  <= hpr_pkg::HPR_SHIFT;
                     remain_reg <= shift_reg;
                  end
               end
            end
            hpr_pkg::HPR_SHIFT: begin
               if (remain_reg == 32'h0000_0000) begin
                  state_reg <= hpr_pkg::HPR_STOP;
               end else if (step) begin
                  remain_reg <= remain_reg - 32'h0000_0001;
               end
            end
            hpr_pkg::HPR_STOP: begin
               if (cur_speed == 16'h0000) begin
                  state_reg <= hpr_pkg::HPR_IDLE;
               end
            end
            default: state_reg <= hpr_pkg::HPR_IDLE;
         endcase
      end
   end

   // ==========================================================================
   // Position counter and home load
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         position_reg     <= 32'h0000_0000;
         servo_on_pos_reg <= 32'h0000_0000;
         homed_reg        <= 1'b0;
      end else begin
         if (servo_edge) begin
            servo_on_pos_reg <= position_reg;
         end
         if (complete) begin
            position_reg <= haddr_home_reg;
            homed_reg    <= 1'b1;
         end else if (state_reg == hpr_pkg::HPR_IDLE && start_edge && homing_mode &&
                      method_reg == hpr_pkg::HPR_M_IGNORE) begin
            position_reg <= haddr_home_reg + (position_reg - servo_on_pos_reg);
            homed_reg    <= 1'b1;
         end else if (step) begin
            position_reg <= dir_reg ? position_reg - 32'h0000_0001
                                    : position_reg + 32'h0000_0001;
         end
         if (state_reg == hpr_pkg::HPR_SEEK) begin
            homed_reg <= 1'b0;
         end
      end
   end

   // ==========================================================================
   // Registered outputs
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         step_pulse    <= 1'b0;
         step_dir      <= `HPR_RST_DIR;
         homing_busy   <= 1'b0;
         home_complete <= 1'b0;
      end else begin
         step_pulse    <= step;
         step_dir      <= dir_reg;
         homing_busy   <= (state_reg != hpr_pkg::HPR_IDLE);
         home_complete <= homed_reg;
      end
   end

   // ==========================================================================
   // AHB-Lite slave, zero wait states, always OKAY
   assign addr_phase = hsel & htrans[1] & hready;

   always_comb begin
      case (haddr[7:0])
         `HPR_OFF_METHOD:   rd_mux = {29'h0, method_reg};
         `HPR_OFF_DIR:      rd_mux = {31'h0, dir_reg};
         `HPR_OFF_POL:      rd_mux = {31'h0, pol_reg};
         `HPR_OFF_HSPEED:   rd_mux = {16'h0, hspeed_reg};
         `HPR_OFF_CREEP:    rd_mux = {16'h0, creep_reg};
         `HPR_OFF_ACC:      rd_mux = {16'h0, acc_reg};
         `HPR_OFF_DEC:      rd_mux = {16'h0, dec_reg};
         `HPR_OFF_SHIFT:    rd_mux = shift_reg;
         `HPR_OFF_HADDR:    rd_mux = haddr_home_reg;
         `HPR_OFF_POSTDOG:  rd_mux = postdog_reg;
         `HPR_OFF_STATUS:   rd_mux = {21'h0, homing_busy, homed_reg, dog_act, 1'b0, state_reg};
         `HPR_OFF_POSITION: rd_mux = position_reg;
         default:           rd_mux = 32'h0000_0000;
      endcase
   end

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         hrdata      <= 32'h0000_0000;
         hreadyout   <= 1'b1;
         hresp       <= 1'b0;
         wr_pend_reg <= 1'b0;
         wr_addr_reg <= 8'h00;
      end else begin
         hreadyout   <= 1'b1;
         hresp       <= 1'b0;
         wr_pend_reg <= addr_phase & hwrite;
         if (addr_phase) begin
            wr_addr_reg <= haddr[7:0];
            hrdata      <= hwrite ? 32'h0000_0000 : rd_mux;
         end
      end
   end

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         method_reg     <= hpr_pkg::hpr_method_t'(`HPR_RST_METHOD);
         dir_reg        <= `HPR_RST_DIR;
         pol_reg        <= `HPR_RST_POL;
         hspeed_reg     <= `HPR_RST_SPEED;
         creep_reg      <= `HPR_RST_SPEED;
         acc_reg        <= `HPR_RST_TC;
         dec_reg        <= `HPR_RST_TC;
         shift_reg      <= `HPR_RST_DIST;
         haddr_home_reg <= `HPR_RST_DIST;
         postdog_reg    <= `HPR_RST_DIST;
      end else if (wr_pend_reg) begin
         case (wr_addr_reg)
            `HPR_OFF_METHOD:  method_reg     <= hpr_pkg::hpr_method_t'(hwdata[2:0]);
            `HPR_OFF_DIR:     dir_reg        <= hwdata[0];
            `HPR_OFF_POL:     pol_reg        <= hwdata[0];
            `HPR_OFF_HSPEED:  hspeed_reg     <= hwdata[15:0];
            `HPR_OFF_CREEP:   creep_reg      <= hwdata[15:0];
            `HPR_OFF_ACC:     acc_reg        <= hwdata[15:0];
            `HPR_OFF_DEC:     dec_reg        <= hwdata[15:0];
            `HPR_OFF_SHIFT:   shift_reg      <= hwdata;
            `HPR_OFF_HADDR:   haddr_home_reg <= hwdata;
            `HPR_OFF_POSTDOG: postdog_reg    <= hwdata;
            default: ;
         endcase
      end
   end

endmodule

// ---- test/hpr_ctrl_model.sv ----
// Purpose: Motion controller and machine model facing the sequencer
// Assumes: Bench pulses go for one cycle with mode_code set
// Notes:   Dog contact closed while the step count is in the window, open there when dog_inv is set
`timescale 1ns/1ps

module hpr_ctrl_model #(
   parameter int DOG_LO = 2,
   parameter int DOG_HI = 3
) (
   input  wire logic        hclk,
   input  wire logic        hresetn,
   input  wire logic        go,
   input  wire logic [2:0]  mode_code,
   input  wire logic        dog_inv,
   input  wire logic        step_pulse,
   output logic             mode_select_bit0,
   output logic             mode_select_bit1,
   output logic             mode_select_bit2,
   output logic             motion_start_input,
   output logic             start_direction_input,
   output logic             dog_switch_input,
   output logic      [15:0] step_count
);
   logic [3:0] seq_cnt;

   // =======================================================================
   // Mode first, start four cycles later
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         {mode_select_bit2, mode_select_bit1, mode_select_bit0} <= 3'h0;
         seq_cnt            <= 4'h0;
         motion_start_input <= 1'b0;
      end else begin
         if (go) begin
            {mode_select_bit2, mode_select_bit1, mode_select_bit0} <= mode_code;
            seq_cnt <= 4'h1;
         end else if (seq_cnt != 4'h0) begin
            seq_cnt <= seq_cnt + 4'h1;
         end
         motion_start_input <= (seq_cnt >= 4'h4) && (seq_cnt < 4'hC);
      end
   end

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         step_count <= 16'h0000;
      end else if (go || step_pulse) begin
         step_count <= go ? 16'h0000 : step_count + 16'h0001;
      end
   end

   // Toggling direction pin must make no difference
   assign start_direction_input = seq_cnt[0];
   assign dog_switch_input      = dog_inv ^ (step_count >= DOG_LO && step_count <= DOG_HI);
endmodule

// ---- test/hpr_top_props.sv ----
// Purpose: Port checks for the homing sequencer
// Assumes: One clock hclk, asynchronous active-low hresetn
// Notes:   Bound to hpr_top from the bench top file
`timescale 1ns/1ps

module hpr_top_props (
   input wire logic        hclk,
   input wire logic        hresetn,
   input wire logic        hsel,
   input wire logic [31:0] haddr,
   input wire logic [1:0]  htrans,
   input wire logic        hwrite,
   input wire logic        hready,
   input wire logic [31:0] hrdata,
   input wire logic        hreadyout,
   input wire logic        hresp,
   input wire logic        mode_select_bit0,
   input wire logic        mode_select_bit1,
   input wire logic        mode_select_bit2,
   input wire logic        motion_start_input,
   input wire logic        step_pulse,
   input wire logic        step_dir,
   input wire logic        homing_busy,
   input wire logic        home_complete
);
   default clocking cb @(posedge hclk);
   endclocking
   default disable iff (!hresetn);

   logic homing_mode;
   assign homing_mode = mode_select_bit0 & ~mode_select_bit1 & ~mode_select_bit2;

   // =======================================================================
   // Bus
   AST_READY_HIGH: assert property (hreadyout) else $error("hreadyout low");
   AST_RESP_OKAY: assert property (!hresp) else $error("hresp not OKAY");
   AST_UNMAPPED_ZERO: assert property (hsel && htrans[1] && !hwrite && hready
      && haddr[7:0] > 8'h2C |=> hrdata == 32'h0000_0000) else $error("unmapped read not 0");

   // =======================================================================
   // Sequence
   AST_MODE_FOR_BUSY: assert property ($rose(homing_busy) |-> homing_mode)
      else $error("search began outside homing mode");
   AST_REFUSED: assert property ($rose(motion_start_input) && !homing_mode
      && !homing_busy |=> !homing_busy [*8]) else $error("start taken in wrong mode");
   AST_START_RUNS: assert property ($rose(motion_start_input) && homing_mode
      && !homing_busy |-> ##[3:8] (homing_busy || home_complete)) else $error("start lost");
   AST_IDLE_STILL: assert property (!homing_busy && !$past(homing_busy) |-> !step_pulse)
      else $error("step while idle");
   AST_DIR_HELD: assert property (homing_busy && $past(homing_busy) |-> $stable(step_dir))
      else $error("direction changed in search");
   AST_STEP_SINGLE: assert property (step_pulse |=> !step_pulse)
      else $error("step wider than one cycle");
   AST_DONE_IDLE: assert property ($rose(home_complete) |-> ##[0:1] !homing_busy)
      else $error("complete while still busy");

   cover property ($rose(home_complete));
   cover property ($rose(homing_busy));
   cover property (step_pulse);
endmodule

// ---- test/test_home_position_return_sequencer.sv ----
// Purpose: Self-checking bench for the homing sequencer
// Assumes: 40 MHz hclk, zero-wait AHB-Lite slave
// Notes:   Speed 0x3000 and time constants 0 keep each search short
`timescale 1ns/1ps
`include "hpr_params.svh"

`define CHK(g, e) begin compares++; if ((g) !== (e)) begin n_fail++; \
   $display("MISMATCH t=%0t got=%0h exp=%0h", $time, (g), (e)); end end

module test_home_position_return_sequencer;
   typedef struct packed {
      logic [2:0]  m;
      logic        dir;
      logic        pol;
      logic        inv;
      logic [31:0] ha;
      logic [31:0] pos;
   } hpr_row_t;

   logic        hclk, hresetn, hsel, hwrite, hreadyout, hresp, go, dog_inv;
   logic        md0, md1, md2, start, sdir, dog, servo_on, step_pulse, step_dir;
   logic        homing_busy, home_complete;
   logic [1:0]  htrans;
   logic [2:0]  hsize, mode_code;
   logic [15:0] step_count;
   logic [31:0] haddr, hwdata, hrdata, d;
   int          n_fail, compares, cycles, n;
   hpr_row_t    rows [4] = '{
      '{hpr_pkg::HPR_M_CNT_FRONT, 1'b0, 1'b1, 1'b0, 32'h0000_0100, 32'h0000_0100},
      '{hpr_pkg::HPR_M_DOG_REAR, 1'b1, 1'b0, 1'b1, 32'h0000_0200, 32'h0000_0200},
      '{hpr_pkg::HPR_M_IGNORE, 1'b0, 1'b1, 1'b0, 32'h0000_0030, 32'h0000_0230},
      '{hpr_pkg::HPR_M_DATASET, 1'b1, 1'b0, 1'b0, 32'h0000_0555, 32'h0000_0555}};
   logic [2:0]  zm [3] = '{3'h0, 3'h6, 3'h1};
   logic [15:0] zs [3] = '{16'h0004, 16'h0002, 16'h0003};

   hpr_top dut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
      .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata),
      .hreadyout(hreadyout), .hresp(hresp), .mode_select_bit0(md0), .mode_select_bit1(md1),
      .mode_select_bit2(md2), .motion_start_input(start), .start_direction_input(sdir),
      .dog_switch_input(dog), .servo_on_input(servo_on), .step_pulse(step_pulse),
      .step_dir(step_dir), .homing_busy(homing_busy), .home_complete(home_complete));

   hpr_ctrl_model ctrl (.hclk(hclk), .hresetn(hresetn), .go(go), .mode_code(mode_code),
      .dog_inv(dog_inv), .step_pulse(step_pulse), .mode_select_bit0(md0),
      .mode_select_bit1(md1), .mode_select_bit2(md2), .motion_start_input(start),
      .start_direction_input(sdir), .dog_switch_input(dog), .step_count(step_count));

   initial begin
      hclk = 1'b0;
      forever #12.5 hclk = ~hclk;
   end

   // =======================================================================
   // Tasks
   task automatic ahb(input logic [7:0] a, input logic w, input logic [31:0] wd,
                      output logic [31:0] rd);
      int k;
      k = 0;
      @(posedge hclk);
      haddr  <= {24'h00_0000, a};
      hwrite <= w;
      htrans <= 2'b10;
      do begin
         @(posedge hclk);
         k++;
      end while (hreadyout !== 1'b1 && k < 64);
      htrans <= 2'b00;
      hwdata <= wd;
      do begin
         @(posedge hclk);
         k++;
      end while (hreadyout !== 1'b1 && k < 128);
      rd = hrdata;
   endtask

   task automatic setup(input hpr_row_t r);
      logic [31:0] x;
      ahb(`HPR_OFF_METHOD, 1'b1, {29'h0, r.m}, x);
      ahb(`HPR_OFF_DIR, 1'b1, {31'h0, r.dir}, x);
      ahb(`HPR_OFF_POL, 1'b1, {31'h0, r.pol}, x);
      ahb(`HPR_OFF_HADDR, 1'b1, r.ha, x);
      ahb(`HPR_OFF_HSPEED, 1'b1, 32'h0000_3000, x);
      ahb(`HPR_OFF_CREEP, 1'b1, 32'h0000_3000, x);
      ahb(`HPR_OFF_ACC, 1'b1, 32'h0000_0000, x);
      ahb(`HPR_OFF_DEC, 1'b1, 32'h0000_0000, x);
      ahb(`HPR_OFF_SHIFT, 1'b1, 32'h0000_0001, x);
      ahb(`HPR_OFF_POSTDOG, 1'b1, 32'h0000_0001, x);
      dog_inv <= r.inv;
   endtask

   task automatic launch(input logic [2:0] mc);
      @(posedge hclk);
      mode_code <= mc;
      go        <= 1'b1;
      @(posedge hclk);
      go        <= 1'b0;
      repeat (16) @(posedge hclk);
   endtask

   task automatic report_and_stop;
      $display("compares=%0d n_fail=%0d", compares, n_fail);
      if (n_fail == 0 && compares > 0)
         $display("TEST PASSED");
      else
         $display("TEST FAILED");
      $finish;
   endtask

   always @(posedge hclk) begin
      cycles++;
      if (cycles == 98000) begin
         n_fail++;
         report_and_stop;
      end
   end

   // =======================================================================
   // Main sequence
   initial begin
      {hresetn, hwrite, go, dog_inv, servo_on, htrans, mode_code} = '0;
      {haddr, hwdata, n_fail, compares, cycles} = '0;
      hsel  = 1'b1;
      hsize = 3'h2;
      repeat (10) @(posedge hclk);
      hresetn <= 1'b1;
      @(posedge hclk);
      servo_on <= 1'b1;
      ahb(`HPR_OFF_METHOD, 1'b0, 32'h0, d);
      `CHK(d, 32'h0000_0000)
      ahb(`HPR_OFF_DIR, 1'b0, 32'h0, d);
      `CHK(d, 32'h0000_0001)
      ahb(`HPR_OFF_POL, 1'b0, 32'h0, d);
      `CHK(d, 32'h0000_0000)
      ahb(8'h40, 1'b0, 32'h0, d);
      `CHK(d, 32'h0000_0000)
      foreach (rows[i]) begin
         setup(rows[i]);
         ahb(`HPR_OFF_HADDR, 1'b0, 32'h0, d);
         `CHK(d, rows[i].ha)
         launch(`HPR_MODE_HOMING);
         `CHK(step_dir, rows[i].dir)
         n = 0;
         while (!(home_complete === 1'b1 && homing_busy === 1'b0) && n < 60000) begin
            @(negedge hclk);
            n++;
         end
         ahb(`HPR_OFF_POSITION, 1'b0, 32'h0, d);
         `CHK(d, rows[i].pos)
         ahb(`HPR_OFF_STATUS, 1'b0, 32'h0, d);
         `CHK({d[10:9], d[6:0]}, 9'h081)
      end
      setup(rows[0]);
      launch(3'h3);
      launch(3'h5);
      `CHK(homing_busy, 1'b0)
      `CHK(home_complete, 1'b1)
      for (int i = 0; i < 3; i++) begin
         setup('{zm[i], 1'b0, 1'b1, 1'b0, 32'h0, 32'h0});
         launch(`HPR_MODE_HOMING);
         n = 0;
         d = 32'h0;
         while (d[6:0] !== 7'h10 && n < 30000) begin
            ahb(`HPR_OFF_STATUS, 1'b0, 32'h0, d);
            n++;
         end
         `CHK(d[6:0], 7'h10)
         `CHK(step_count, zs[i])
         @(posedge hclk);
         hresetn <= 1'b0;
         repeat (2) @(posedge hclk);
         hresetn <= 1'b1;
      end
      report_and_stop;
   end
endmodule

bind hpr_top hpr_top_props u_props (.hclk(hclk), .hresetn(hresetn), .hsel(hsel),
   .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hready(hready), .hrdata(hrdata),
   .hreadyout(hreadyout), .hresp(hresp), .mode_select_bit0(mode_select_bit0),
   .mode_select_bit1(mode_select_bit1), .mode_select_bit2(mode_select_bit2),
   .motion_start_input(motion_start_input), .step_pulse(step_pulse), .step_dir(step_dir),
   .homing_busy(homing_busy), .home_complete(home_complete));
